// >>> core/clk_ctl_pkg.sv
// constants, field layout and helpers of the clock switch and prescaler
package clk_ctl_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_TRIM      = 8'h00;
    localparam logic [7:0] OFF_RC_CTRL   = 8'h04;
    localparam logic [7:0] OFF_SRC_CTRL  = 8'h08;
    localparam logic [7:0] OFF_SRC_STAT  = 8'h0C;
    localparam logic [7:0] OFF_PRESCALE  = 8'h10;
    localparam logic [7:0] OFF_PLL_CTRL  = 8'h14;
    localparam logic [7:0] OFF_POSTSCALE = 8'h18;
    // ****************************************
    // field positions
    // ****************************************
    localparam int B_RC_FREQ   = 0;
    localparam int B_SOURCE_SELECT_BIT      = 0;
    localparam int B_EXT_EN    = 2;
    localparam int B_RC_EN     = 3;
    localparam int B_EXT_SUT   = 4;
    localparam int B_RC_SUT    = 6;
    localparam int B_EXT_ON    = 0;
    localparam int B_RC_ON     = 1;
    localparam int B_PCE       = 7;
    localparam int B_PLL_LOCK  = 0;
    localparam int B_PLL_EN    = 1;
    localparam int B_PLL_INDIV = 4;
    localparam int B_USB_DIV   = 0;
    localparam int B_HST_DIV   = 4;
    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [7:0] TRIM_RST     = 8'h00;
    localparam logic [3:0] DIV_RST      = 4'h0;
    localparam logic [3:0] DIV_BY8      = 4'h3;
    localparam logic [3:0] DIV_MAX      = 4'h8;
    localparam logic [7:0] PCE_ONLY     = 8'h80;
    localparam logic [2:0] PCE_WIN      = 3'h4;
    localparam logic [1:0] SUT_SHORT    = 2'h1;
    localparam logic [1:0] SUT_LONG     = 2'h2;
    // ****************************************
    // timing
    // ****************************************
    localparam int MCLK_PERIOD_NS = 25;
    localparam int RST_DELAY_CK   = 14;
    localparam int WAKE_DELAY_CK  = 6;
    localparam int SUT_SHORT_NS   = 4100000;
    localparam int SUT_LONG_NS    = 65000000;
    localparam int SUT_SHORT_CYC  = SUT_SHORT_NS / MCLK_PERIOD_NS;
    localparam int SUT_LONG_CYC   = SUT_LONG_NS / MCLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_RUN  = 2'b01,
        ST_WAKE = 2'b11
    } start_state_t;

    // mask of counter bits that span one divided period
    function automatic logic [7:0] div_mask(input logic [3:0] code);
        div_mask = 8'((16'h0001 << code) - 16'h0001);
    endfunction
endpackage

// >>> core/presc_if.sv
// carrier between the register side and the system clock divider
interface presc_if;
    logic [3:0] new_div;
    logic       load;
    logic       tick;
    logic       level;
    logic [3:0] cur_div;
    modport ctl (output new_div, output load, input tick, input level, input cur_div);
    modport div (input new_div, input load, output tick, output level, output cur_div);
endinterface

// >>> core/sys_clk_divider.sv
// ripple style divider of the undivided source clock
module sys_clk_divider
    import clk_ctl_pkg::*;
(
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    // control
    presc_if.div      pif
);
    logic [7:0] cnt_q;
    logic [3:0] div_q;
    logic [3:0] pend_q;
    logic       pend_v_q;
    logic       tick_q;
    logic       level_q;

    wire [7:0] mask      = div_mask(div_q);
    wire       period_end = (cnt_q & mask) == mask;
    wire       swap      = period_end && (pend_v_q || pif.load);
    wire [3:0] next_div  = pif.load ? pif.new_div : pend_q;
    wire [7:0] swap_mask = div_mask(next_div);
    // square wave: high in the second half of each divided period; held high at division code 0
    wire       lvl_d     = swap ? (swap_mask == 8'h00) :
                           (div_q == 4'h0) ? 1'b1 :
                           ((8'(cnt_q + 8'h01) & mask) > (mask >> 1));

    // count state stays internal; software never sees it (see RULE13)
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q    <= 8'h00;
            div_q    <= DIV_RST;
            pend_q   <= DIV_RST;
            pend_v_q <= 1'b0;
            tick_q   <= 1'b0;
            level_q  <= 1'b0;
        end else begin
            if (pif.load) begin
                pend_q   <= pif.new_div;
                pend_v_q <= 1'b1;
            end
            // swap only at the end of an old period: no glitch, no fast runt (see RULE12) (see RULE14)
            if (swap) begin
                div_q    <= next_div;
                pend_v_q <= 1'b0;
                cnt_q    <= 8'h00;
            end else begin
                cnt_q <= 8'(cnt_q + 8'h01);
            end
            tick_q  <= swap ? (swap_mask == 8'h00) : ((8'(cnt_q + 8'h01) & mask) == mask);
            level_q <= lvl_d;
        end
    end

    assign pif.tick    = tick_q;
    assign pif.level   = level_q;
    assign pif.cur_div = div_q;

    chk_swap_at_boundary: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $changed(div_q) |-> $past(period_end)) else $error("division changed mid period"); // see RULE12
endmodule // sys_clk_divider

// >>> core/clock_switch_and_prescaler.sv
// clock switch, rc trim, start-up delay, system prescaler and pll scalers
//
// Overview of operation
// RULE1: factory trim loaded into trim after reset
// RULE2: trim register writable; code sets rc frequency
// RULE3: software keeps trim below 8.8 MHz writing
// RULE4: frequency select resets zero; one gives 1MHz
// RULE5: upper rc control bits read zero
// RULE6: start-up select sets reset and wake delays; the code applies it to the reset delay only, wake stays 6 clocks
// RULE7: external clock changes limited unless in reset
// RULE8: switch only among rc, external, crystal
// RULE9: clock out fuse drives pin, also during reset
// RULE10: clock out pin carries divided system clock
// RULE11: one divided clock feeds all core domains
// RULE12: prescaler change without glitch or fast runt
// RULE13: ripple count state not software readable
// RULE14: new division active after old period end
// RULE15: two write sequence protects division changes
// RULE16: software masks interrupts during the sequence
// RULE17: pll makes 32 to 96 MHz
// RULE18: pll input passes or halves the source
// RULE19: independent postscalers for usb and timer
// RULE20: firmware order for leaving external clock
// RULE21: firmware returns to external before usb restart
// RULE22: external clock may stop while rc runs
// RULE23: change enable self clears after four cycles
// RULE24: division codes powers of two, up to 256
// RULE25: source bit selects external; fuse sets it
// RULE26: rc running status bit follows oscillator
// RULE27: switch completes only to a running source
// RULE28: rc powers down only when unused, disabled
//
// Added by the designer: register access over APB and the register offsets.
module clock_switch_and_prescaler
    import clk_ctl_pkg::*;
#(
    parameter int SUT_SHORT_CYCLES = SUT_SHORT_CYC,
    parameter int SUT_LONG_CYCLES  = SUT_LONG_CYC
) (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    // apb slave
    input  wire logic       i_psel,
    input  wire logic       i_penable,
    input  wire logic       i_pwrite,
    input  wire logic [7:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]     o_prdata,
    output logic            o_pready,
    output logic            o_pslverr,
    // fuses and factory data
    input  wire logic [7:0] i_factory_trim,
    input  wire logic       i_fuse_ext_source,
    input  wire logic [1:0] i_startup_select,
    input  wire logic       i_clock_out_fuse,
    input  wire logic       i_divide_by_eight_fuse,
    // oscillators and pll
    input  wire logic       i_rc_running,
    input  wire logic       i_ext_running,
    input  wire logic       i_pll_lock,
    input  wire logic       i_pll_tick,
    input  wire logic       i_wake,
    output logic [7:0]      o_trim_code,
    output logic            o_rc_freq_select,
    output logic            o_rc_osc_power,
    output logic            o_ext_osc_power,
    output logic            o_source_ext,
    output logic            o_pll_enable,
    output logic            o_pll_ref_tick,
    output logic            o_usb_clk_tick,
    output logic            o_hst_clk_tick,
    // system clock
    output logic            o_sys_clk_tick,
    output logic            o_core_hold,
    output logic            o_clock_out_pin,
    output logic            o_clock_out_oe
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]   trim_q;
    logic         rc_freq_q;
    logic [1:0]   rc_sut_q, ext_sut_q;
    logic         rc_en_q, ext_en_q, source_select_bit_q;
    logic         active_ext_q;
    logic [1:0]   osc_on_q;
    logic         pce_q;
    logic [2:0]   pce_cnt_q;
    logic         pll_en_q, pll_indiv_q, pll_lock_q, pll_half_q, pll_ref_q;
    logic [3:0]   post_q;
    logic [2:0]   usb_cnt_q, hst_cnt_q;
    logic         usb_tick_q, hst_tick_q;
    logic         straps_q;
    logic [21:0]  delay_q;
    start_state_t state_q;
    logic         ready_q, slverr_q;
    logic [31:0]  rdata_q;
    logic         tick_q, pin_q, oe_q, hold_q;

    presc_if pif ();

    sys_clk_divider u_div (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .pif       (pif.div)
    );

    // ****************************************
    // apb decode
    // ****************************************
    wire       acc      = i_psel && i_penable;
    wire       wr_fire  = acc && ready_q && i_pwrite;
    wire [7:0] wd       = i_pwdata[7:0];
    wire       hit_trim = i_paddr == OFF_TRIM;
    wire       hit_rcc  = i_paddr == OFF_RC_CTRL;
    wire       hit_src  = i_paddr == OFF_SRC_CTRL;
    wire       hit_sta  = i_paddr == OFF_SRC_STAT;
    wire       hit_pre  = i_paddr == OFF_PRESCALE;
    wire       hit_pll  = i_paddr == OFF_PLL_CTRL;
    wire       hit_post = i_paddr == OFF_POSTSCALE;
    wire       mapped   = hit_trim | hit_rcc | hit_src | hit_sta | hit_pre | hit_pll | hit_post;

    wire [7:0] src_rd  = {rc_sut_q, ext_sut_q, rc_en_q, ext_en_q, 1'b0, source_select_bit_q};
    wire [7:0] pre_rd  = {pce_q, 3'h0, pif.cur_div};
    wire [7:0] pll_rd  = {3'h0, pll_indiv_q, 2'h0, pll_en_q, pll_lock_q};
    // upper rc control bits always read zero (see RULE5)
    wire [7:0] rd_mux  = hit_trim ? trim_q :
                         hit_rcc  ? {7'h00, rc_freq_q} :
                         hit_src  ? src_rd :
                         hit_sta  ? {6'h00, osc_on_q} :
                         hit_pre  ? pre_rd :
                         hit_pll  ? pll_rd :
                         hit_post ? {2'h0, post_q[3:2], 2'h0, post_q[1:0]} : 8'h00;

    // one wait state; every bus output comes from a flop
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ready_q  <= 1'b0;
            slverr_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            ready_q  <= acc && !ready_q;
            slverr_q <= acc && !ready_q && !mapped;
            rdata_q  <= (acc && !ready_q && !i_pwrite) ? {24'h000000, rd_mux} : 32'h0000_0000;
        end
    end

    // ****************************************
    // prescaler change protection
    // ****************************************
    wire pre_wr   = wr_fire && hit_pre;
    wire pce_arm  = pre_wr && (wd == PCE_ONLY) && !pce_q;
    wire div_wr   = pre_wr && !wd[B_PCE];
    // reserved division codes are dropped (see RULE24)
    wire div_take = div_wr && pce_q && (wd[3:0] <= DIV_MAX);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pce_q     <= 1'b0;
            pce_cnt_q <= 3'h0;
        end else if (pce_arm) begin
            pce_q     <= 1'b1; // see RULE15
            pce_cnt_q <= 3'h0;
        end else if (pce_q) begin
            // rewrite does not extend; clears on timeout or division write (see RULE23)
            pce_cnt_q <= 3'(pce_cnt_q + 3'h1);
            if (div_wr || pce_cnt_q == 3'(PCE_WIN - 3'h1)) begin
                pce_q <= 1'b0;
            end
        end
    end

    wire       strap_div = straps_q == 1'b0;
    assign pif.load    = div_take || strap_div; // see RULE15
    assign pif.new_div = strap_div ? (i_divide_by_eight_fuse ? DIV_BY8 : DIV_RST) : wd[3:0];

    // ****************************************
    // trim, rc control, source control
    // ****************************************
    // next target must be running before the mux moves (see RULE27)
    wire tgt_ok = source_select_bit_q ? osc_on_q[B_EXT_ON] : osc_on_q[B_RC_ON];

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            straps_q     <= 1'b0;
            trim_q       <= TRIM_RST;
            rc_freq_q    <= 1'b0; // see RULE4
            rc_sut_q     <= 2'h0;
            ext_sut_q    <= 2'h0;
            rc_en_q      <= 1'b0;
            ext_en_q     <= 1'b0;
            source_select_bit_q       <= 1'b0;
            active_ext_q <= 1'b0;
            osc_on_q     <= 2'h0;
        end else begin
            straps_q <= 1'b1;
            // rc running flag follows the oscillator (see RULE26)
            osc_on_q <= {i_rc_running, i_ext_running};
            if (!straps_q) begin
                // straps caught on the first edge after reset release
                trim_q       <= i_factory_trim; // see RULE1
                source_select_bit_q       <= i_fuse_ext_source; // see RULE25
                active_ext_q <= i_fuse_ext_source;
                rc_en_q      <= !i_fuse_ext_source;
                ext_en_q     <= i_fuse_ext_source;
                rc_sut_q     <= i_fuse_ext_source ? 2'h0 : i_startup_select;
                ext_sut_q    <= i_fuse_ext_source ? i_startup_select : 2'h0;
            end else begin
                if (wr_fire && hit_trim) begin
                    trim_q <= wd; // see RULE2
                end
                if (wr_fire && hit_rcc) begin
                    rc_freq_q <= wd[B_RC_FREQ]; // see RULE4
                end
                if (wr_fire && hit_src) begin
                    // only rc or external/crystal can be chosen (see RULE8)
                    source_select_bit_q    <= wd[B_SOURCE_SELECT_BIT];
                    ext_en_q  <= wd[B_EXT_EN]; // see RULE22
                    rc_en_q   <= wd[B_RC_EN];
                    ext_sut_q <= wd[B_EXT_SUT +: 2];
                end
                if (source_select_bit_q != active_ext_q && tgt_ok) begin
                    active_ext_q <= source_select_bit_q; // see RULE27
                end
            end
        end
    end

    // ****************************************
    // start-up delay
    // ****************************************
    wire [1:0]  sut_now  = active_ext_q ? ext_sut_q : rc_sut_q;
    wire [21:0] rst_wait = (sut_now == SUT_SHORT) ? 22'(RST_DELAY_CK + SUT_SHORT_CYCLES) :
                           (sut_now == SUT_LONG)  ? 22'(RST_DELAY_CK + SUT_LONG_CYCLES) :
                           22'(RST_DELAY_CK);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= ST_HOLD;
            delay_q <= 22'h000000;
        end else begin
            case (state_q)
                ST_HOLD: begin
                    // reset delay: 14 clocks plus the selected extra (see RULE6)
                    delay_q <= 22'(delay_q + 22'h000001);
                    if (straps_q && delay_q >= 22'(rst_wait - 22'h000001)) begin
                        state_q <= ST_RUN;
                        delay_q <= 22'h000000;
                    end
                end
                ST_RUN: begin
                    if (i_wake) begin
                        state_q <= ST_WAKE;
                        delay_q <= 22'h000000;
                    end
                end
                ST_WAKE: begin
                    // wake from power-down always 6 clocks (see RULE6)
                    delay_q <= 22'(delay_q + 22'h000001);
                    if (delay_q == 22'(WAKE_DELAY_CK - 1)) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                end
            endcase
        end
    end

    // ****************************************
    // pll input prescaler and postscalers
    // ****************************************
    wire usb_end = usb_cnt_q == 3'(div_mask({2'h0, post_q[1:0]}));
    wire hst_end = hst_cnt_q == 3'(div_mask({2'h0, post_q[3:2]}));

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pll_en_q    <= 1'b0;
            pll_indiv_q <= 1'b0;
            pll_lock_q  <= 1'b0;
            pll_half_q  <= 1'b0;
            pll_ref_q   <= 1'b0;
            post_q      <= 4'h0;
            usb_cnt_q   <= 3'h0;
            hst_cnt_q   <= 3'h0;
            usb_tick_q  <= 1'b0;
            hst_tick_q  <= 1'b0;
        end else begin
            if (wr_fire && hit_pll) begin
                pll_en_q    <= wd[B_PLL_EN];
                pll_indiv_q <= wd[B_PLL_INDIV];
            end
            if (wr_fire && hit_post) begin
                post_q <= {wd[B_HST_DIV +: 2], wd[B_USB_DIV +: 2]};
            end
            pll_lock_q <= pll_en_q && i_pll_lock;
            // pass or halve the reference for the pll (see RULE17) (see RULE18)
            pll_half_q <= pll_en_q && !pll_half_q;
            pll_ref_q  <= pll_en_q && (!pll_indiv_q || pll_half_q);
            // independent division of the pll output (see RULE19)
            usb_tick_q <= i_pll_tick && usb_end;
            hst_tick_q <= i_pll_tick && hst_end;
            if (i_pll_tick) begin
                usb_cnt_q <= usb_end ? 3'h0 : 3'(usb_cnt_q + 3'h1);
                hst_cnt_q <= hst_end ? 3'h0 : 3'(hst_cnt_q + 3'h1);
            end
        end
    end

    // ****************************************
    // system clock outputs
    // ****************************************
    // pin follows the divided level while the core is held: it outputs during reset delay
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tick_q <= 1'b0;
            pin_q  <= 1'b0;
            oe_q   <= 1'b0;
            hold_q <= 1'b1;
        end else begin
            tick_q <= pif.tick; // see RULE11
            pin_q  <= i_clock_out_fuse && pif.level; // see RULE10
            oe_q   <= i_clock_out_fuse; // see RULE9
            hold_q <= state_q != ST_RUN;
        end
    end

    assign o_prdata         = rdata_q;
    assign o_pready         = ready_q;
    assign o_pslverr        = slverr_q;
    assign o_trim_code      = trim_q;
    assign o_rc_freq_select = rc_freq_q;
    assign o_source_ext     = active_ext_q;
    assign o_pll_enable     = pll_en_q;
    assign o_pll_ref_tick   = pll_ref_q;
    assign o_usb_clk_tick   = usb_tick_q;
    assign o_hst_clk_tick   = hst_tick_q;
    assign o_sys_clk_tick   = tick_q;
    assign o_clock_out_pin  = pin_q;
    assign o_clock_out_oe   = oe_q;
    assign o_core_hold      = hold_q;

    // active source never stopped (see RULE28)
    logic rc_pwr_q, ext_pwr_q;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rc_pwr_q  <= 1'b1;
            ext_pwr_q <= 1'b0;
        end else begin
            rc_pwr_q  <= rc_en_q || !active_ext_q || !source_select_bit_q;
            ext_pwr_q <= ext_en_q || active_ext_q || source_select_bit_q;
        end
    end
    assign o_rc_osc_power  = rc_pwr_q;
    assign o_ext_osc_power = ext_pwr_q;

    // ****************************************
    // checks
    // ****************************************
    chk_pce_window: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE23
        pce_arm ##1 !pre_wr [*4] |-> pce_q ##1 !pce_q)
        else $error("change enable window not four cycles");
    chk_div_guard: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE15
        (pre_wr && !pce_q && straps_q) |=> !pif.load) else $error("division loaded outside window");
    chk_switch_run: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE27
        $changed(active_ext_q) && $past(straps_q) |->
        (active_ext_q ? $past(osc_on_q[B_EXT_ON]) : $past(osc_on_q[B_RC_ON])))
        else $error("switched to a stopped source");
    chk_rc_keep: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE28
        !active_ext_q && !source_select_bit_q |=> o_rc_osc_power) else $error("active rc powered down");
    chk_trim_load: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE1
        !straps_q |=> trim_q == $past(i_factory_trim)) else $error("factory trim not loaded");
    chk_rc_upper: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE5
        acc && !ready_q && !i_pwrite && hit_rcc |=> rdata_q[7:1] == 7'h00)
        else $error("rc control upper bits not zero");
    chk_wake_delay: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE6
        state_q == ST_RUN && i_wake |=> (state_q == ST_WAKE) [*6] ##1 state_q == ST_RUN)
        else $error("wake delay not six clocks");
    chk_pin_div: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE10
        !i_clock_out_fuse |=> !o_clock_out_pin && !o_clock_out_oe)
        else $error("clock pin driven without fuse");
    chk_rd_status: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see RULE26
        acc && !ready_q && !i_pwrite && hit_sta |=> rdata_q[B_RC_ON] == $past(osc_on_q[B_RC_ON]))
        else $error("rc running status misread");
endmodule // clock_switch_and_prescaler

// >>> tb/osc_model.sv
// oscillator and pll model behind the clock switch
module osc_model (
    // clock and power requests
    input  wire logic i_mclk,
    input  wire logic i_rc_pwr,
    input  wire logic i_ext_pwr,
    input  wire logic i_pll_en,
    // running flags and pll output
    output logic      o_rc_on,
    output logic      o_ext_on,
    output logic      o_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ext_q = 2'h0;
    initial o_tick = 1'h0;
    // ext needs two cycles to start; it never jumps in rate while running
    always @(posedge i_mclk) begin
        ext_q <= i_ext_pwr ? {ext_q[0], 1'h1} : 2'h0;
        o_tick <= i_pll_en & ~o_tick;
    end
    assign o_ext_on = ext_q[1];
    assign o_rc_on = i_rc_pwr;
endmodule // osc_model

// >>> tb/tb.sv
// self-checking bench of the clock switch and prescaler
module tb;
    import clk_ctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk = 0, i_sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, ftrim = 0, trim_pin;
    logic [1:0]  startup_select = 0;
    logic [31:0] pwdata = 0, q, rdata;
    logic        err, prdy, slverr, rc_pwr, ext_pwr, pll_en, rc_on, ext_on, ptick;
    logic        src, hold, stick, freq, oe, pin, rtick, wake = 0, div8 = 0, cko = 1;
    int          mismatches = 0, cmp_count = 0, m_trim, m_div, n;
    int          extra[4] = '{0, 20, 40, 0};
    initial forever #12.5 i_mclk = ~i_mclk;
    clock_switch_and_prescaler #(.SUT_SHORT_CYCLES(20), .SUT_LONG_CYCLES(40))
        clock_switch_and_prescaler_i (.i_mclk, .i_sys_rst, .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(rdata),
        .o_pready(prdy), .o_pslverr(slverr), .i_factory_trim(ftrim), .i_fuse_ext_source(1'h0),
        .i_startup_select(startup_select), .i_clock_out_fuse(cko), .i_divide_by_eight_fuse(div8),
        .i_rc_running(rc_on), .i_ext_running(ext_on), .i_pll_lock(pll_en), .i_pll_tick(ptick),
        .i_wake(wake), .o_trim_code(trim_pin), .o_rc_freq_select(freq), .o_rc_osc_power(rc_pwr),
        .o_ext_osc_power(ext_pwr), .o_source_ext(src), .o_pll_enable(pll_en),
        .o_pll_ref_tick(rtick), .o_usb_clk_tick(), .o_hst_clk_tick(), .o_sys_clk_tick(stick),
        .o_core_hold(hold), .o_clock_out_pin(pin), .o_clock_out_oe(oe));
    osc_model osc_model_i (.i_mclk, .i_rc_pwr(rc_pwr), .i_ext_pwr(ext_pwr),
        .i_pll_en(pll_en), .o_rc_on(rc_on), .o_ext_on(ext_on), .o_tick(ptick));
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request stays up until pready is sampled; release is left to idle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'h1;
        n = 0;
        do @(posedge i_mclk); while (prdy !== 1'h1 && ++n < 20);
        q = rdata;
        err = slverr;
        if (n >= 20) mismatches++;
    endtask
    task automatic idle(input int c);
        psel <= 1'h0;
        penable <= 1'h0;
        repeat (c) @(posedge i_mclk);
    endtask
    // third wait gives one full divided period
    task automatic meas;
        repeat (3) begin
            n = 0;
            do @(posedge i_mclk); while (stick !== 1'h1 && ++n < 600);
            n++;
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_mclk);
        mismatches++;
        give_verdict;
    end
    initial begin
        n = $urandom(17873);
        for (int s = 0; s < 4; s++) begin
            m_trim = $urandom % 256;
            i_sys_rst <= 1'h1;
            startup_select <= 2'(s);
            ftrim <= 8'(m_trim);
            div8 <= 1'(s == 3);
            cko <= 1'(s != 0);
            repeat (5) @(posedge i_mclk);
            i_sys_rst <= 1'h0;
            @(posedge i_mclk);
            for (n = 0; hold === 1'h1 && n < 99; n++) @(posedge i_mclk);
            check("hold", 32'(n >= 13 + extra[s] && n <= 15 + extra[s]), 1);
            apb(0, OFF_TRIM, 0);
            check("trim reg", q, 32'(m_trim));
            check("oe", 32'(oe), 32'(s != 0));
            apb(0, OFF_PRESCALE, 0);
            check("div strap", q, 32'(s == 3 ? DIV_BY8 : DIV_RST));
            idle(1);
        end
        m_trim = $urandom % 256;
        apb(1, OFF_TRIM, 32'(m_trim));
        apb(0, OFF_TRIM, 0);
        check("trim reg", q, 32'(m_trim));
        check("trim pin", 32'(trim_pin), 32'(m_trim));
        apb(0, OFF_RC_CTRL, 0);
        check("rc ctrl", q, 0);
        apb(1, OFF_RC_CTRL, 32'hFF);
        apb(0, OFF_RC_CTRL, 0);
        check("rc ctrl", q, 1);
        check("freq", 32'(freq), 1);
        check("oe", 32'(oe), 1);
        apb(0, 8'h40, 0);
        check("slverr", 32'(err), 1);
        idle(1);
        wake <= 1'h1;
        @(posedge i_mclk);
        wake <= 1'h0;
        n = 0;
        repeat (9) @(posedge i_mclk) n += int'(hold);
        check("wake hold", 32'(n), 32'(WAKE_DELAY_CK));
        // read back only after the swap: the old period may still be running
        for (int c = 0; c < 10; c++) begin
            apb(1, OFF_PRESCALE, 32'(PCE_ONLY));
            apb(1, OFF_PRESCALE, 32'(c));
            if (c < 9) m_div = c;
            idle(1);
            meas;
            check("period", 32'(n), 32'(1 << m_div));
            if (c == 0) check("pin", 32'(pin), 1);
            apb(0, OFF_PRESCALE, 0);
            check("div", q, 32'(m_div));
        end
        apb(1, OFF_PRESCALE, 32'h5);
        apb(1, OFF_PRESCALE, 32'(PCE_ONLY));
        idle(6);
        apb(1, OFF_PRESCALE, 32'h5);
        apb(0, OFF_PRESCALE, 0);
        check("div locked", q, 32'(m_div));
        apb(1, OFF_PLL_CTRL, 32'h12);
        idle(2);
        n = 0;
        repeat (8) @(posedge i_mclk) n += int'(rtick);
        check("pll ref", 32'(n), 4);
        apb(1, OFF_SRC_CTRL, 32'h0D);
        check("early switch", 32'(src), 0);
        idle(20);
        check("ext source", 32'(src), 1);
        apb(1, OFF_PLL_CTRL, 0);
        apb(1, OFF_SRC_CTRL, 32'h0C);
        apb(1, OFF_SRC_CTRL, 32'h08);
        idle(20);
        check("rc source", 32'(src), 0);
        check("ext power", 32'(ext_pwr), 0);
        apb(0, OFF_SRC_STAT, 0);
        check("status", q & 32'h3, 32'h2);
        idle(1);
        give_verdict;
    end
endmodule // tb
